// >>> ase_axis_sync_event_select.v
// Two-axis synchronous event selection, wait status and interrupt
// gating. Assumes comparator conditions, profile levels, busy flags
// and start requests are synchronous to clock from the axis logic.
// Register map, word address on reg_addr, axis group in bits 3:2
//    0..3  X axis group
//    4..7  Y axis group
//    8..15 unused, read as zero, writes ignored
// Registers within a group, by reg_addr bits 1:0
//    0  environment five, write only
//       bits 19:16 output timing selector
//       bits 21:20 input selector
//    1  status, read only, bits 3:0 condition code
//    2  interrupt cause select, write only, bits 12:4
//    3  sticky event flags, write one to clear, bits 12:4
// Event bit order, shared by select and flag registers
//    4  accel start        5  accel done
//    6  decel start        7  decel done
//    8..12 comparators one to five
// Start modes, two bits per axis on start_mode
//    0, 3  start at once
//    1     wait for the selected sync input
//    2     wait for the other axis to go idle
//
// Timing, counted from the edge that first sees an input change
//    sync_out pulses in the next cycle, for one cycle only
//    sticky flag sets on that edge, int_n falls a cycle later
//    start_go pulses a cycle after the request or wait end
//    read data stand only in the cycle after the read strobe
//
// Limitations
//    a level must drop before the same source fires again
//    start requests during a wait are dropped, not queued
//    input selector codes 10 and 11 leave the axis no source
//    a clearing write loses to an event in the same cycle
//
`include "ase_regs.vh"

module ase_axis_sync_event_select #(
   parameter NCMP = 5
) (
   input  wire          clock,
   input  wire          rst,
   input  wire [3:0]    reg_addr,
   input  wire [31:0]   reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output wire [31:0]   reg_rdata,
   input  wire [9:0]    cmp_cond,
   input  wire [1:0]    accel_act,
   input  wire [1:0]    decel_act,
   input  wire [1:0]    axis_busy,
   input  wire [7:0]    axis_cnd,
   input  wire [1:0]    start_req,
   input  wire [3:0]    start_mode,
   output wire [1:0]    sync_out,
   output wire [1:0]    start_go,
   output wire          int_n
);

   // One-hot start sequencer states
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_WSYNC = 3'b010;
   localparam [2:0] ST_WSTOP = 3'b100;

   localparam NEV = `ASE_IRQ_MSB - `ASE_IRQ_LSB + 1;

   // Full word addresses of the readable registers, four bits wide
   localparam [3:0] ADR_X_STS = `ASE_XBASE | {2'b00, `ASE_OFS_STS};
   localparam [3:0] ADR_X_EVT = `ASE_XBASE | {2'b00, `ASE_OFS_EVT};
   localparam [3:0] ADR_Y_STS = `ASE_YBASE | {2'b00, `ASE_OFS_STS};
   localparam [3:0] ADR_Y_EVT = `ASE_YBASE | {2'b00, `ASE_OFS_EVT};

   // Per-axis views gathered for the read mux and the interrupt
   wire [63:0]  sts_w;
   wire [63:0]  evt_w;
   wire [1:0]   pend_w;

   reg  [31:0]  rdata_r;
   reg          int_n_r;

   genvar a;
   generate
      // One copy of the selection logic per axis; the only
      // cross-axis paths are the sync source and the busy flag,
      // so both axes behave alike whatever their order
      for (a = 0; a < 2; a = a + 1) begin : ax
         localparam [3:0] AB = a ? `ASE_YBASE : `ASE_XBASE;

         reg  [31:0]     env5_r;
         reg  [31:0]     irqsel_r;
         reg  [NEV-1:0]  evt_r;
         reg  [NEV-1:0]  evt_nxt;
         reg  [NCMP-1:0] cmp_prev_r;
         reg             acc_prev_r;
         reg             dec_prev_r;
         reg             sync_r;
         reg             go_r;
         reg  [2:0]      st_r;
         reg  [2:0]      st_nxt;
         reg             go_nxt;
         reg             fire;
         reg             sync_in;
         reg  [3:0]      cnd;

         wire [NCMP-1:0] cmp_now;
         wire [NCMP-1:0] cmp_rise;
         wire            acc_beg;
         wire            acc_end;
         wire            dec_beg;
         wire            dec_end;
         wire [NEV-1:0]  ev;
         wire [3:0]      syo;
         wire [1:0]      syi;
         wire [1:0]      mode;
         wire            other_busy;
         wire            grp;

         assign grp = (reg_addr[3:2] == AB[3:2]);
         assign cmp_now = cmp_cond[a*NCMP +: NCMP];
         assign mode = start_mode[a*2 +: 2];
         assign other_busy = axis_busy[1-a];

         // Field extraction from environment five
         assign syo = env5_r[`ASE_SYO_MSB:`ASE_SYO_LSB];
         assign syi = env5_r[`ASE_SYI_MSB:`ASE_SYI_LSB];

         // Edge detectors turn levels into one-cycle events.
         // History resets low, matching the idle level of every
         // source, so no false event follows reset. Adds no
         // latency, as the live level is compared with the registered history.
         assign cmp_rise = cmp_now & ~cmp_prev_r;
         assign acc_beg = accel_act[a] & ~acc_prev_r;
         assign acc_end = ~accel_act[a] & acc_prev_r;
         assign dec_beg = decel_act[a] & ~dec_prev_r;
         assign dec_end = ~decel_act[a] & dec_prev_r;

         // Event order follows the select bits 4..12
         assign ev = {cmp_rise, dec_end, dec_beg, acc_end, acc_beg};

         // Output timing selection; only edges, so one pulse per event.
         // A held level cannot retrigger the partner axis, which
         // would otherwise start again on every cycle.
         // Unassigned codes fall to the default and stay silent.
         always @* begin
            case (syo)
               `ASE_SYO_CMP1:    fire = cmp_rise[0];
               `ASE_SYO_CMP2:    fire = cmp_rise[1];
               `ASE_SYO_CMP3:    fire = cmp_rise[2];
               `ASE_SYO_CMP4:    fire = cmp_rise[3];
               `ASE_SYO_CMP5:    fire = cmp_rise[4];
               `ASE_SYO_ACC_BEG: fire = acc_beg;
               `ASE_SYO_ACC_END: fire = acc_end;
               `ASE_SYO_DEC_BEG: fire = dec_beg;
               `ASE_SYO_DEC_END: fire = dec_end;
               default:          fire = 1'b0;
            endcase
         end

         // Source of this axis's synchronous input.
         // Taken from the registered pulses, so the start that
         // follows lands two cycles after the selected event.
         always @* begin
            case (syi)
               `ASE_SYI_X: sync_in = sync_out[0];
               `ASE_SYI_Y: sync_in = sync_out[1];
               default:    sync_in = 1'b0;
            endcase
         end

         // Start sequencer; a plain start needs no waiting.
         // A stop wait with the other axis already idle goes at
         // once rather than parking for a cycle.
         // Requests that arrive while waiting are ignored.
         always @* begin
            st_nxt = st_r;
            go_nxt = 1'b0;
            case (st_r)
               ST_IDLE: begin
                  if (start_req[a]) begin
                     case (mode)
                        `ASE_START_SYNC: st_nxt = ST_WSYNC;
                        `ASE_START_STOP: begin
                           if (other_busy) begin
                              st_nxt = ST_WSTOP;
                           end else begin
                              go_nxt = 1'b1;
                           end
                        end
                        default: go_nxt = 1'b1;
                     endcase
                  end
               end
               ST_WSYNC: begin
                  if (sync_in) begin
                     st_nxt = ST_IDLE;
                     go_nxt = 1'b1;
                  end
               end
               ST_WSTOP: begin
                  if (!other_busy) begin
                     st_nxt = ST_IDLE;
                     go_nxt = 1'b1;
                  end
               end
               default: st_nxt = ST_IDLE;
            endcase
         end

         // Wait codes override the condition reported by the axis
         always @* begin
            case (st_r)
               ST_WSYNC: cnd = `ASE_CND_WSYNC;
               ST_WSTOP: cnd = `ASE_CND_WSTOP;
               default:  cnd = axis_cnd[a*4 +: 4];
            endcase
         end

         // Sticky events: a new event beats a clearing write.
         // Losing an event is worse than one spare interrupt,
         // hence the set is applied after the clear.
         always @* begin
            evt_nxt = evt_r;
            if (reg_wr && grp && reg_addr[1:0] == `ASE_OFS_EVT) begin
               evt_nxt = evt_r &
                  ~reg_wdata[`ASE_IRQ_MSB:`ASE_IRQ_LSB];
            end
            evt_nxt = evt_nxt | ev;
         end

         // Registers, edge history and sequencer state.
         // Whole words are stored; unused bits are harmless
         // because only the defined fields are ever decoded.
         always @(posedge clock) begin
            if (rst) begin
               env5_r     <= `ASE_ENV5_RST;
               irqsel_r   <= `ASE_IRQSEL_RST;
               evt_r      <= {NEV{1'b0}};
               cmp_prev_r <= {NCMP{1'b0}};
               acc_prev_r <= 1'b0;
               dec_prev_r <= 1'b0;
               sync_r     <= 1'b0;
               go_r       <= 1'b0;
               st_r       <= ST_IDLE;
            end else begin
               if (reg_wr && grp && reg_addr[1:0] == `ASE_OFS_ENV5) begin
                  env5_r <= reg_wdata;
               end
               if (reg_wr && grp &&
                   reg_addr[1:0] == `ASE_OFS_IRQSEL) begin
                  irqsel_r <= reg_wdata;
               end
               evt_r      <= evt_nxt;
               cmp_prev_r <= cmp_now;
               acc_prev_r <= accel_act[a];
               dec_prev_r <= decel_act[a];
               sync_r     <= fire;
               go_r       <= go_nxt;
               st_r       <= st_nxt;
            end
         end

         // Outputs straight from flip-flops, one bit per axis
         assign sync_out[a] = sync_r;
         assign start_go[a] = go_r;
         assign sts_w[a*32 +: 32] = {28'h0000000, cnd};
         assign evt_w[a*32 +: 32] = {19'h00000, evt_r, 4'h0};

         // Select bits gate sticky events onto the interrupt
         assign pend_w[a] = |(evt_r &
            irqsel_r[`ASE_IRQ_MSB:`ASE_IRQ_LSB]);
      end
   endgenerate

   // Read data one cycle after the strobe; write-only registers read 0.
   // Zero outside the read cycle, so a late sample by the host
   // never shows stale data as if it were fresh.
   always @(posedge clock) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            ADR_X_STS:
               rdata_r <= sts_w[31:0];
            ADR_X_EVT:
               rdata_r <= evt_w[31:0];
            ADR_Y_STS:
               rdata_r <= sts_w[63:32];
            ADR_Y_EVT:
               rdata_r <= evt_w[63:32];
            default:
               rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   // Active-low level interrupt from either axis.
   // Registered so that no glitch of the gating logic can
   // reach the pin; costs one cycle of interrupt latency.
   always @(posedge clock) begin
      if (rst) begin
         int_n_r <= 1'b1;
      end else begin
         int_n_r <= ~(|pend_w);
      end
   end

   assign reg_rdata = rdata_r;
   assign int_n = int_n_r;

endmodule

// >>> ase_regs.vh
// Register map and codes of the axis synchronous event select block.
// Assumes word addressing on a plain strobe port, 32-bit data.
`ifndef ASE_REGS_VH
`define ASE_REGS_VH

// Axis register groups
`define ASE_XBASE 4'h0
`define ASE_YBASE 4'h4

// Offsets within an axis group
`define ASE_OFS_ENV5 2'h0
`define ASE_OFS_STS 2'h1
`define ASE_OFS_IRQSEL 2'h2
`define ASE_OFS_EVT 2'h3

// Environment five fields
`define ASE_SYO_LSB 16
`define ASE_SYO_MSB 19
`define ASE_SYI_LSB 20
`define ASE_SYI_MSB 21
`define ASE_ENV5_RST 32'h0000_0000

// Output timing selector codes
`define ASE_SYO_CMP1 4'h1
`define ASE_SYO_CMP2 4'h2
`define ASE_SYO_CMP3 4'h3
`define ASE_SYO_CMP4 4'h4
`define ASE_SYO_CMP5 4'h5
`define ASE_SYO_ACC_BEG 4'h8
`define ASE_SYO_ACC_END 4'h9
`define ASE_SYO_DEC_BEG 4'ha
`define ASE_SYO_DEC_END 4'hb

// Input selector codes
`define ASE_SYI_X 2'h0
`define ASE_SYI_Y 2'h1

// Status condition codes
`define ASE_CND_WSYNC 4'h3
`define ASE_CND_WSTOP 4'h4

// Interrupt select and event field
`define ASE_IRQ_LSB 4
`define ASE_IRQ_MSB 12
`define ASE_IRQSEL_RST 32'h0000_0000

// Start modes
`define ASE_START_NOW 2'h0
`define ASE_START_SYNC 2'h1
`define ASE_START_STOP 2'h2

`endif

// >>> ase_monitor.sv
// Port checker for the axis event select block, X axis side.
// Assumes the bench never requests a start on a waiting axis.
module ase_monitor (
   input wire        clock,
   input wire        rst,
   input wire [3:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire [9:0]  cmp_cond,
   input wire [1:0]  accel_act,
   input wire [1:0]  decel_act,
   input wire [1:0]  axis_busy,
   input wire [1:0]  start_req,
   input wire [3:0]  start_mode,
   input wire [1:0]  sync_out,
   input wire [1:0]  start_go,
   input wire        int_n
);
   reg  [3:0] syo_r;
   reg  [1:0] irq_r;
   reg        acc_en_r;
   wire       cmp_sel = syo_r >= 4'h1 && syo_r <= 4'h5;
   wire       ok_syo = cmp_sel || (syo_r >= 4'h8 && syo_r <= 4'hb);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Shadows of write-only fields, since they cannot be read back
   always @(posedge clock) begin
      if (rst) begin
         syo_r <= 4'h0;
         irq_r <= 2'h0;
         acc_en_r <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == 4'h0) syo_r <= reg_wdata[19:16];
         if (reg_addr == 4'h2) irq_r[0] <= |reg_wdata[12:4];
         if (reg_addr == 4'h2) acc_en_r <= reg_wdata[4];
         if (reg_addr == 4'h6) irq_r[1] <= |reg_wdata[12:4];
      end
   end
   chk_pulse_once: assert property (
      sync_out[0] |=> !sync_out[0])
      else $error("sync pulse longer than one cycle");
   chk_cmp_fire: assert property (cmp_sel
      && $rose(cmp_cond[syo_r - 4'h1]) |=> sync_out[0])
      else $error("comparator match gave no sync pulse");
   chk_code_off: assert property (!ok_syo && $stable(syo_r)
      |-> !sync_out[0]) else $error("sync pulse on unassigned code");
   chk_accel_fire: assert property ((syo_r == 4'h8
      && $rose(accel_act[0]) || syo_r == 4'h9 && $fell(accel_act[0]))
      |=> sync_out[0]) else $error("accel event gave no sync pulse");
   chk_decel_fire: assert property ((syo_r == 4'ha
      && $rose(decel_act[0]) || syo_r == 4'hb && $fell(decel_act[0]))
      |=> sync_out[0]) else $error("decel event gave no sync pulse");
   chk_irq_raise: assert property (acc_en_r
      && $rose(accel_act[0]) |-> ##[1:3] !int_n)
      else $error("enabled event raised no interrupt");
   chk_irq_quiet: assert property (irq_r == 2'h0
      && $past(irq_r) == 2'h0 |-> int_n)
      else $error("interrupt with every cause masked");
   chk_stop_hold: assert property (start_req[0]
      && start_mode[1:0] == 2'h2 && axis_busy[1] |=> !start_go[0])
      else $error("start granted while other axis busy");
endmodule
bind ase_axis_sync_event_select ase_monitor u_mon (.clock, .rst,
   .reg_addr, .reg_wdata, .reg_wr, .cmp_cond, .accel_act, .decel_act,
   .axis_busy, .start_req, .start_mode, .sync_out, .start_go, .int_n);

// >>> ase_testbench.sv
// Self-checking bench for the axis event select block.
// Assumes the checker file is compiled alongside.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   reg  [3:0]  reg_addr = 4'h0;
   reg  [31:0] reg_wdata = 32'h0;
   reg         clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   reg  [9:0]  cmp_cond = 10'h0;
   reg  [1:0]  accel_act = 2'h0, decel_act = 2'h0, axis_busy = 2'h0;
   reg  [1:0]  start_req = 2'h0;
   reg  [7:0]  axis_cnd = 8'h52;
   reg  [3:0]  start_mode = 4'h6;
   wire [31:0] reg_rdata;
   wire [1:0]  sync_out, start_go;
   wire        int_n;
   integer     error_cnt = 0, compares = 0, cyc = 0, e, c, m, n, b;
   ase_axis_sync_event_select uut (.clock, .rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .cmp_cond, .accel_act, .decel_act,
      .axis_busy, .axis_cnd, .start_req, .start_mode, .sync_out,
      .start_go, .int_n);
   initial forever #2 clock = ~clock;
   // Hang guard, far above the roughly 1200 cycles needed
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         close_out;
      end
   end
   task close_out;
      if (error_cnt == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task check(input [31:0] got, input [31:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task rd(input [3:0] a, input [31:0] x);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, x);
   endtask
   // Event k on X: cmp1..5, accel up/down, decel up/down; counts pulses
   task ev(input integer k);
      @(posedge clock);
      if (k < 5) cmp_cond[k] <= 1'b1;
      else if (k < 7) accel_act[0] <= (k == 5);
      else decel_act[0] <= (k == 7);
      n = 0;
      repeat (4) begin
         @(posedge clock);
         #1 if (sync_out[0] === 1'b1) n = n + 1;
      end
      @(posedge clock);
      cmp_cond[4:0] <= 5'h0;
   endtask
   task go_chk(input integer a, input integer x);
      n = 0;
      repeat (4) begin
         @(posedge clock);
         #1 if (start_go[a] === 1'b1) n = n + 1;
      end
      check(n, x);
   endtask
   task req(input integer a);
      @(posedge clock);
      start_req[a] <= 1'b1;
      @(posedge clock);
      start_req[a] <= 1'b0;
   endtask
   task cmp_go(input integer k, input integer x);
      @(posedge clock);
      cmp_cond[k] <= 1'b1;
      go_chk(1, x);
      @(posedge clock);
      cmp_cond[k] <= 1'b0;
   endtask
   // Every selector code against every event source
   task t_sync_codes;
      for (c = 0; c < 16; c = c + 1) begin
         wr(4'h0, c << 16);
         for (e = 0; e < 9; e = e + 1) begin
            ev(e);
            check(n, c == (e < 5 ? e + 1 :
               e + 3));
         end
      end
   endtask
   // A neighbour of each cause enabled first, then the cause itself
   task t_irq;
      wr(4'h3, 32'h1ff0);
      for (m = 0; m < 2; m = m + 1)
         for (e = 0; e < 9; e = e + 1) begin
            b = e < 5 ? e + 8 : e - 1;
            wr(4'h2, 32'h1 << (m ? b : (b == 12 ? 4 : b + 1)));
            ev(e);
            check(int_n, !m);
            rd(4'h3, 32'h1 << b);
            wr(4'h3, 32'h1 << b);
            rd(4'h3, 32'h0);
            check(int_n, 1'b1);
         end
      wr(4'h2, 32'h0);
   endtask
   // Y waits for sync from X then from Y; X waits for Y to stop
   task t_start;
      rd(4'h8, 32'h0);
      wr(4'h4, 32'h0001_0000);
      rd(4'h4, 32'h0);
      wr(4'h0, 32'h0001_0000);
      req(1);
      rd(4'h5, 32'h3);
      cmp_go(5, 0);
      cmp_go(0, 1);
      rd(4'h5, 32'h5);
      wr(4'h4, 32'h0011_0000);
      req(1);
      cmp_go(0, 0);
      cmp_go(5, 1);
      @(posedge clock);
      axis_busy[1] <= 1'b1;
      req(0);
      rd(4'h1, 32'h4);
      go_chk(0, 0);
      @(posedge clock);
      axis_busy[1] <= 1'b0;
      go_chk(0, 1);
      rd(4'h1, 32'h2);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      t_sync_codes;
      t_irq;
      t_start;
      close_out;
   end
endmodule
